// File: bench/test_tuner_synth_bus_control.sv
// Self-checking bench for the synthesiser serial control block
`timescale 1ns/1ps
`default_nettype none
module test_tuner_synth_bus_control;
    import tsbc_pkg::*;
    logic       clk, rst_n, ref_clk, lo, run_clks;
    logic [1:0] sel, lo_ph;
    logic [7:0] ports_in;
    wire  logic scl, sda, sda_oe, p_up, p_dn, cur, drv, lock;
    wire  logic [7:0] p_oe;
    int         err_count, n_compared, ref_ph, ref_edges, lo_edges, hits;
    tsbc_top uut (.sys_clk_in(clk), .reset_n_in(rst_n), .scl_in(scl), .sda_in(sda),
        .sda_oe_out(sda_oe), .addr_select_port_in(sel), .adc_code_in(3'h5),
        .ref_clk_in(ref_clk), .lo_in(lo), .output_ports_in(ports_in),
        .output_ports_oe_out(p_oe), .pump_up_out(p_up), .pump_down_out(p_dn),
        .pump_current_select_out(cur), .drive_output_off_out(drv), .lock_flag_out(lock));
    tsbc_host_model host (.sys_clk_in(clk), .sda_oe_in(sda_oe), .scl_out(scl), .sda_out(sda));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Reference every 25 cycles, prescaler input every 4, rising edges counted
    always @(posedge clk) begin
        if (run_clks) begin
            ref_ph <= (ref_ph == 24) ? 0 : ref_ph + 1;
            ref_clk <= (ref_ph < 12);
            ref_edges <= ref_edges + ((ref_ph == 0) ? 1 : 0);
            lo_ph <= lo_ph + 2'h1;
            lo <= lo_ph[1];
            lo_edges <= lo_edges + ((lo_ph == 2'h2) ? 1 : 0);
        end
        hits <= hits + ((p_up === 1'b1 || p_dn === 1'b1) ? 1 : 0);
    end
    task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("compared=%0d mismatches=%0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic port_rise(input int idx, output int at);
        int t;
        t = 0;
        while (p_oe[idx] !== 1'b0 && t < 20000) begin
            @(posedge clk);
            t++;
        end
        while (p_oe[idx] !== 1'b1 && t < 40000) begin
            @(posedge clk);
            t++;
        end
        at = (idx == 6) ? ref_edges : lo_edges;
    endtask
    task automatic t_address();
        logic ack;
        for (int p = 0; p < 4; p++) begin
            for (int s = 0; s < 4; s++) begin
                @(posedge clk);
                sel <= p[1:0];
                host.start_cond();
                host.addr(s[1:0], 1'b0, ack);
                host.stop_cond();
                check_val({15'h0, ack}, {15'h0, (s == p) || (s == 1)});
            end
        end
    endtask
    task automatic t_write();
        logic ack;
        logic [7:0] q;
        @(posedge clk);
        sel <= 2'h0;
        host.start_cond();
        host.addr(2'h0, 1'b0, ack);
        host.xfer(8'hcf, 1'b0, q, ack);
        check_val({15'h0, ack}, 16'h0001);
        host.xfer(8'ha5, 1'b0, q, ack);
        check_val({6'h0, cur, drv, p_oe}, 16'h03a5);
        host.xfer(8'h8e, 1'b0, q, ack);
        host.xfer(8'h3c, 1'b0, q, ack);
        check_val({6'h0, cur, drv, p_oe}, 16'h003c);
        host.xfer(8'hcf, 1'b0, q, ack);
        host.partial(4'h9);
        host.stop_cond();
        check_val({6'h0, cur, drv, p_oe}, 16'h033c);
    endtask
    task automatic t_read();
        logic ack;
        logic [7:0] q;
        host.start_cond();
        host.addr(2'h0, 1'b1, ack);
        host.xfer(8'hff, 1'b1, q, ack);
        check_val({8'h0, q}, 16'h00b5);
        host.xfer(8'hff, 1'b0, q, ack);
        check_val({8'h0, q}, 16'h00b5);
        host.stop_cond();
        host.start_cond();
        host.addr(2'h0, 1'b1, ack);
        host.xfer(8'hff, 1'b0, q, ack);
        host.stop_cond();
        check_val({8'h0, q}, 16'h0035);
    endtask
    task automatic t_divider();
        logic ack;
        logic [7:0] q;
        int a, b, h;
        host.start_cond();
        host.addr(2'h0, 1'b0, ack);
        host.xfer(8'h00, 1'b0, q, ack);
        host.xfer(8'h03, 1'b0, q, ack);
        host.xfer(8'hbe, 1'b0, q, ack);
        host.stop_cond();
        run_clks <= 1'b1;
        h = hits;
        port_rise(6, a);
        port_rise(6, b);
        check_val(16'(b - a), 16'(int'(4000000.0 / 7812.5)));
        port_rise(7, a);
        port_rise(7, b);
        check_val(16'(b - a), 16'(8 * 3));
        check_val(16'(hits - h), 16'h0000);
        host.start_cond();
        host.addr(2'h0, 1'b0, ack);
        host.xfer(8'hae, 1'b0, q, ack);
        host.stop_cond();
        h = hits;
        port_rise(6, a);
        port_rise(6, b);
        check_val({15'h0, hits > h}, 16'h0001);
        check_val({15'h0, lock}, 16'h0000);
    endtask
    initial begin
        repeat (90000) @(posedge clk);
        err_count++;
        summarize();
    end
    initial begin
        {rst_n, ref_clk, lo, run_clks, lo_ph, sel} = '0;
        ports_in = 8'ha0;
        {err_count, n_compared, ref_ph, ref_edges, lo_edges, hits} = '0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        check_val({5'h0, sda_oe, cur, drv, p_oe}, 16'h0000);
        t_address();
        t_write();
        t_read();
        t_divider();
        summarize();
    end
endmodule
`default_nettype wire

// File: bench/tsbc_host_model.sv
// Bus controller model on the two-wire serial lines
`timescale 1ns/1ps
`default_nettype none
module tsbc_host_model (
    // Clock
    input  wire logic sys_clk_in,
    // Serial lines
    input  wire logic sda_oe_in,
    output var  logic scl_out,
    output wire logic sda_out
);
    logic pull;
    initial begin
        scl_out = 1'b1;
        pull = 1'b0;
    end
    // Pulled-up wire, low when either side pulls
    assign sda_out = ~(pull | sda_oe_in);
    task automatic wait_n(input int n);
        repeat (n) @(posedge sys_clk_in);
    endtask
    task automatic start_cond();
        pull <= 1'b0;
        wait_n(4);
        scl_out <= 1'b1;
        wait_n(4);
        pull <= 1'b1;
        wait_n(4);
        scl_out <= 1'b0;
        wait_n(4);
    endtask
    task automatic stop_cond();
        pull <= 1'b1;
        wait_n(4);
        scl_out <= 1'b1;
        wait_n(4);
        pull <= 1'b0;
        wait_n(8);
    endtask
    // Data set while clock low, line sampled mid high
    task automatic bit_cycle(input logic b, output logic v);
        pull <= ~b;
        wait_n(4);
        scl_out <= 1'b1;
        wait_n(2);
        v = sda_out;
        wait_n(2);
        scl_out <= 1'b0;
        wait_n(1);
    endtask
    task automatic xfer(input logic [7:0] d, input logic host_ack,
                        output logic [7:0] q, output logic ack);
        logic v;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(d[i], v);
            q[i] = v;
        end
        bit_cycle(~host_ack, v);
        ack = ~v;
    endtask
    task automatic addr(input logic [1:0] sel, input logic rd, output logic ack);
        logic [7:0] q;
        xfer({tsbc_pkg::ADDR_HEAD, sel, rd}, 1'b0, q, ack);
    endtask
    task automatic partial(input logic [3:0] d);
        logic v;
        for (int i = 3; i >= 0; i--) begin
            bit_cycle(d[i], v);
        end
    endtask
endmodule
`default_nettype wire

// File: bench/tsbc_top_chk.sv
// Port checks for the synthesiser serial control block
`timescale 1ns/1ps
`default_nettype none
module tsbc_top_chk #(
    parameter int LOCK_WINDOW = 4,
    parameter int LOCK_COUNT  = 4
) (
    // Clock and reset
    input wire logic       sys_clk_in,
    input wire logic       reset_n_in,
    // Serial bus
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       sda_oe_out,
    // Ports and pump
    input wire logic [7:0] output_ports_oe_out,
    input wire logic       pump_up_out,
    input wire logic       pump_down_out,
    input wire logic       pump_current_select_out,
    input wire logic       drive_output_off_out
);
    logic       scl_q;
    logic [3:0] since_fall;
    logic [3:0] next_since_fall;
    // Cycles since the last serial clock fall, saturating
    assign next_since_fall = (scl_q && !scl_in) ? 4'h0 :
                             (since_fall == 4'hf) ? 4'hf : since_fall + 4'h1;
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            scl_q      <= 1'b1;
            since_fall <= 4'hf;
        end else begin
            scl_q      <= scl_in;
            since_fall <= next_since_fall;
        end
    end
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);
    sequence scl_held;
        scl_in && $past(scl_in) && $past(scl_in, 2);
    endsequence
    sequence stop_seen;
        scl_in && $past(scl_in) && sda_in && !$past(sda_in);
    endsequence
    reset_quiet_a: assert property ($rose(reset_n_in) |->
        output_ports_oe_out == 8'h00 && !sda_oe_out && !pump_up_out && !pump_down_out)
        else $error("outputs not quiet after reset");
    sda_hold_a: assert property (scl_held |-> $stable(sda_oe_out))
        else $error("data line changed while serial clock high");
    oe_after_fall_a: assert property ($changed(sda_oe_out) |-> since_fall <= 4'h2)
        else $error("data drive changed away from a clock fall");
    port_update_a: assert property ($changed(output_ports_oe_out[5:0]) |-> since_fall <= 4'h3)
        else $error("port enables changed outside a byte commit");
    current_update_a: assert property ($changed(pump_current_select_out) |-> since_fall <= 4'h3)
        else $error("pump current changed outside a byte commit");
    drive_update_a: assert property ($changed(drive_output_off_out) |-> since_fall <= 4'h3)
        else $error("drive switch changed outside a byte commit");
    pump_clear_a: assert property ($fell(pump_up_out) |-> !pump_down_out)
        else $error("pump pulses not cleared together");
    stop_idle_a: assert property (stop_seen |=> !sda_oe_out [*3])
        else $error("data line driven after stop");
endmodule
bind tsbc_top tsbc_top_chk #(.LOCK_WINDOW(LOCK_WINDOW), .LOCK_COUNT(LOCK_COUNT)) chk (
    .sys_clk_in, .reset_n_in, .scl_in, .sda_in, .sda_oe_out, .output_ports_oe_out,
    .pump_up_out, .pump_down_out, .pump_current_select_out, .drive_output_off_out);
`default_nettype wire

// File: hw/tsbc_bus_if.sv
// Byte carrier between the serial slave and the synthesiser core
`timescale 1ns/1ps
`default_nettype none
interface tsbc_bus_if;
    logic [1:0] addr_sel;
    logic [7:0] tx_byte;
    logic [7:0] rx_byte;
    logic       rx_valid;
    logic       wr_start;
    logic       read_stop;
    modport slv  (input addr_sel, tx_byte, output rx_byte, rx_valid, wr_start, read_stop);
    modport core (output addr_sel, tx_byte, input rx_byte, rx_valid, wr_start, read_stop);
endinterface
`default_nettype wire

// File: hw/tsbc_i2c_slave.sv
// Two-wire serial slave: address match, byte receive, status send
`timescale 1ns/1ps
`default_nettype none
module tsbc_i2c_slave (
    // Clock and reset
    input  wire logic sys_clk_in,
    input  wire logic reset_n_in,
    // Serial lines
    input  wire logic scl_in,
    input  wire logic sda_in,
    output var  logic sda_oe_out,
    // Core side
    tsbc_bus_if.slv   bus
);
    import tsbc_pkg::*;
    tsbc_bus_state_t state;
    logic       scl_q;
    logic       sda_q;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic       rd_mode;
    wire scl_rise   = scl_in & ~scl_q;
    wire scl_fall   = ~scl_in & scl_q;
    wire start_cond = scl_in & scl_q & sda_q & ~sda_in;
    wire stop_cond  = scl_in & scl_q & ~sda_q & sda_in;
    wire byte_done  = scl_fall & (bit_cnt == 4'h8);
    wire addr_hit   = (shift[7:3] == ADDR_HEAD) &&
                      ((shift[2:1] == bus.addr_sel) || (shift[2:1] == ADDR_SEL_FIXED));
    wire [7:0] next_shift = {shift[6:0], sda_in};

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state <= TSBC_IDLE;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            bit_cnt <= 4'h0;
            shift <= 8'h00;
            rd_mode <= 1'b0;
            sda_oe_out <= 1'b0;
            bus.rx_byte <= 8'h00;
            bus.rx_valid <= 1'b0;
            bus.wr_start <= 1'b0;
            bus.read_stop <= 1'b0;
        end else begin
            scl_q <= scl_in;
            sda_q <= sda_in;
            bus.rx_valid <= 1'b0;
            bus.wr_start <= 1'b0;
            bus.read_stop <= 1'b0;
            if (start_cond) begin
                state <= TSBC_ADDR;
                bit_cnt <= 4'h0;
                sda_oe_out <= 1'b0;
            end else if (stop_cond) begin
                state <= TSBC_IDLE;
                sda_oe_out <= 1'b0;
                bus.read_stop <= rd_mode;
                rd_mode <= 1'b0;
            end else begin
                unique case (state)
                    TSBC_IDLE: begin
                    end
                    TSBC_ADDR, TSBC_WR: begin
                        if (scl_rise) begin
                            shift <= next_shift;
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                        if (byte_done && state == TSBC_ADDR) begin
                            if (addr_hit) begin
                                sda_oe_out <= 1'b1;
                                rd_mode <= shift[0];
                                bus.wr_start <= ~shift[0];
                                state <= TSBC_ADDR_ACK;
                            end else begin
                                state <= TSBC_IDLE;
                            end
                        end else if (byte_done) begin
                            bus.rx_byte <= shift;
                            bus.rx_valid <= 1'b1;
                            sda_oe_out <= 1'b1;
                            state <= TSBC_WR_ACK;
                        end
                    end
                    TSBC_ADDR_ACK, TSBC_RD_NEXT: begin
                        if (scl_fall) begin
                            bit_cnt <= 4'h0;
                            if (rd_mode) begin
                                shift <= bus.tx_byte;
                                sda_oe_out <= ~bus.tx_byte[7];
                                state <= TSBC_RD;
                            end else begin
                                sda_oe_out <= 1'b0;
                                state <= TSBC_WR;
                            end
                        end
                    end
                    TSBC_WR_ACK: begin
                        if (scl_fall) begin
                            sda_oe_out <= 1'b0;
                            bit_cnt <= 4'h0;
                            state <= TSBC_WR;
                        end
                    end
                    TSBC_RD: begin
                        if (scl_rise) begin
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                        if (byte_done) begin
                            sda_oe_out <= 1'b0;
                            state <= TSBC_RD_ACK;
                        end else if (scl_fall) begin
                            sda_oe_out <= ~shift[6];
                            shift <= {shift[6:0], 1'b0};
                        end
                    end
                    TSBC_RD_ACK: begin
                        if (scl_rise) begin
                            state <= sda_in ? TSBC_IDLE : TSBC_RD_NEXT;
                        end
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// File: hw/tsbc_pkg.sv
// Constants for the tuner synthesiser serial control block
package tsbc_pkg;
    // Fixed address head, sent before the two select bits
    localparam logic [4:0] ADDR_HEAD      = 5'h18;
    localparam logic [1:0] ADDR_SEL_FIXED = 2'h1;
    // Control byte fields, bit 1 being the MSB (index 7)
    localparam int CTRL_CP_POS = 6;
    localparam int CTRL_T1_POS = 5;
    localparam int CTRL_T0_POS = 4;
    localparam int CTRL_OS_POS = 0;
    localparam int PORT_ADC    = 6;
    localparam int PORT_TOP    = 7;
    // Values after reset
    localparam logic [14:0] RATIO_RESET = 15'h0000;
    localparam logic [7:0]  CTRL_RESET  = 8'h00;
    localparam logic [7:0]  PORT_RESET  = 8'h00;
    // Reference and comparison rates
    localparam longint REF_FREQ_HZ         = 4000000;
    localparam longint COMP_FREQ_MILLIHZ   = 7812500;
    localparam int     REF_DIVIDE          = int'((REF_FREQ_HZ * 1000) / COMP_FREQ_MILLIHZ);
    localparam int     PRESCALE            = 8;
    // Lock detection: bound that error cycles per period must stay below, periods in a row
    localparam int     LOCK_WINDOW_CYCLES  = 4;
    localparam int     LOCK_PERIODS        = 4;
    typedef enum {TSBC_IDLE, TSBC_ADDR, TSBC_ADDR_ACK, TSBC_WR, TSBC_WR_ACK,
                  TSBC_RD, TSBC_RD_ACK, TSBC_RD_NEXT} tsbc_bus_state_t;
    typedef enum {TSBC_CLS_ANY, TSBC_CLS_FREQ_LO, TSBC_CLS_PORT} tsbc_class_t;
endpackage

// File: hw/tsbc_top.sv
// Synthesiser control core: byte steering, dividers, comparator, ports
//
// Function
// - Address LSB high selects status read, low selects programming write.
// - Device pulls data low in acknowledge slots of address and written bytes.
// - Address select input chooses one address the device answers; select code 1 is always answered too.
// - First bit of each new byte: 0 frequency byte, 1 control byte.
// - Frequency byte pairs with low frequency byte; control pairs with port byte.
// - Further bytes are accepted in one write until a stop.
// - A byte cut short before its eighth bit is discarded.
// - Frequency bits held in 15-bit register setting the programmable divider.
// - Fixed divide-by-8 prescaler precedes the programmable divider.
// - Phase comparator drives the pump to lock divider to comparison rate.
// - Reference divided by fixed ratio to give 7.8125 kHz comparison.
// - Control bit 2 selects high pump current when 1, low when 0.
// - Control bit 4 set turns the charge pump off.
// - Control bit 8 set forces the varactor drive output off.
// - Control bit 3 routes comparison to ADC port, divider to top port.
// - Port byte bit 1 turns a port on, 0 leaves it high impedance.
// - Bytes MSB first; address is 11000, two select bits, direction bit.
// - Status byte: power-on, lock, three port levels, three ADC bits.
// - Power-on flag set on supply loss, cleared by stop ending a read.
// - All output ports start high impedance at power-up.
`timescale 1ns/1ps
`default_nettype none
module tsbc_top #(
    parameter int LOCK_WINDOW = tsbc_pkg::LOCK_WINDOW_CYCLES,
    parameter int LOCK_COUNT  = tsbc_pkg::LOCK_PERIODS
) (
    // Clock and reset
    input  wire logic       sys_clk_in,
    input  wire logic       reset_n_in,
    // Serial bus
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output var  logic       sda_oe_out,
    // Address select level code and ADC result
    input  wire logic [1:0] addr_select_port_in,
    input  wire logic [2:0] adc_code_in,
    // Reference and prescaler input edges
    input  wire logic       ref_clk_in,
    input  wire logic       lo_in,
    // Output ports: enable pulls the port low
    input  wire logic [7:0] output_ports_in,
    output var  logic [7:0] output_ports_oe_out,
    // Charge pump, drive amplifier and lock flag
    output var  logic       pump_up_out,
    output var  logic       pump_down_out,
    output var  logic       pump_current_select_out,
    output var  logic       drive_output_off_out,
    output var  logic       lock_flag_out
);
    import tsbc_pkg::*;

    initial begin
        if (LOCK_WINDOW < 1 || LOCK_WINDOW > 255 || LOCK_COUNT < 1 || LOCK_COUNT > 255) begin
            $error("tsbc_top: lock parameters out of range");
        end
        if (REF_DIVIDE != 512) begin
            $error("tsbc_top: reference divider must be 512");
        end
    end

    tsbc_bus_if bus ();

    tsbc_i2c_slave u_slave (
        .sys_clk_in (sys_clk_in),
        .reset_n_in (reset_n_in),
        .scl_in     (scl_in),
        .sda_in     (sda_in),
        .sda_oe_out (sda_oe_out),
        .bus        (bus.slv)
    );

    // Programming registers
    logic [14:0] divider_ratio;
    logic [7:0]  pump_test_control;
    logic [7:0]  port_output_control;
    tsbc_class_t byte_class;
    logic        power_on_flag;

    // Divider chain state
    logic        ref_q;
    logic        lo_q;
    logic [8:0]  ref_cnt;
    logic [2:0]  pre_cnt;
    logic [14:0] div_cnt;
    logic        comp_sq;
    logic        div_sq;

    // Comparator state
    logic        pfd_up;
    logic        pfd_dn;
    logic [7:0]  err_cnt;
    logic [7:0]  lock_cnt;

    // Control field decode
    wire pump_current_select    = pump_test_control[CTRL_CP_POS];
    wire comparator_test_select = pump_test_control[CTRL_T1_POS];
    wire pump_disable           = pump_test_control[CTRL_T0_POS];
    wire drive_output_off       = pump_test_control[CTRL_OS_POS];

    // Edge detection on sampled reference and prescaler input
    wire ref_edge  = ref_clk_in & ~ref_q;
    wire lo_edge   = lo_in & ~lo_q;
    wire comp_tick = ref_edge && (ref_cnt == 9'(REF_DIVIDE - 1));
    wire pre_tick  = lo_edge && (pre_cnt == 3'(PRESCALE - 1));
    wire div_tick  = pre_tick && (div_cnt <= 15'h0001);

    // Phase-frequency detector next state
    wire next_up   = (pfd_up | comp_tick) & ~(pfd_dn | div_tick);
    wire next_dn   = (pfd_dn | div_tick) & ~(pfd_up | comp_tick);
    wire in_window = err_cnt < 8'(LOCK_WINDOW);
    wire locked    = lock_cnt >= 8'(LOCK_COUNT);

    // Status byte sent on read
    assign bus.tx_byte  = {power_on_flag, lock_flag_out, output_ports_in[7],
                           output_ports_in[5], output_ports_in[4], adc_code_in};
    assign bus.addr_sel = addr_select_port_in;

    // Port drive with test routing
    logic [7:0] next_port_oe;
    always_comb begin
        next_port_oe = port_output_control;
        if (comparator_test_select) begin
            next_port_oe[PORT_ADC] = ~comp_sq;
            next_port_oe[PORT_TOP] = ~div_sq;
        end
    end

    // Byte steering of the write stream
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            divider_ratio <= RATIO_RESET;
            pump_test_control <= CTRL_RESET;
            port_output_control <= PORT_RESET;
            byte_class <= TSBC_CLS_ANY;
        end else if (bus.wr_start) begin
            byte_class <= TSBC_CLS_ANY;
        end else if (bus.rx_valid) begin
            unique case (byte_class)
                TSBC_CLS_ANY: begin
                    if (!bus.rx_byte[7]) begin
                        divider_ratio[14:8] <= bus.rx_byte[6:0];
                        byte_class <= TSBC_CLS_FREQ_LO;
                    end else begin
                        pump_test_control <= bus.rx_byte;
                        byte_class <= TSBC_CLS_PORT;
                    end
                end
                TSBC_CLS_FREQ_LO: begin
                    divider_ratio[7:0] <= bus.rx_byte;
                    byte_class <= TSBC_CLS_ANY;
                end
                TSBC_CLS_PORT: begin
                    port_output_control <= bus.rx_byte;
                    byte_class <= TSBC_CLS_ANY;
                end
            endcase
        end
    end

    // Power-on indicator
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            power_on_flag <= 1'b1;
        end else if (bus.read_stop) begin
            power_on_flag <= 1'b0;
        end
    end

    // Reference divider and comparison square wave
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ref_q <= 1'b0;
            ref_cnt <= 9'h000;
            comp_sq <= 1'b0;
        end else begin
            ref_q <= ref_clk_in;
            if (ref_edge) begin
                ref_cnt <= comp_tick ? 9'h000 : ref_cnt + 9'h001;
            end
            if (ref_edge) begin
                comp_sq <= comp_tick || (ref_cnt < 9'(REF_DIVIDE / 2 - 1));
            end
        end
    end

    // Prescaler and programmable divider
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            lo_q <= 1'b0;
            pre_cnt <= 3'h0;
            div_cnt <= RATIO_RESET;
            div_sq <= 1'b0;
        end else begin
            lo_q <= lo_in;
            if (lo_edge) begin
                pre_cnt <= pre_cnt + 3'h1;
            end
            if (div_tick) begin
                div_cnt <= divider_ratio;
                div_sq <= 1'b1;
            end else if (pre_tick) begin
                div_cnt <= div_cnt - 15'h0001;
            end
            if (lo_edge && !div_tick) begin
                div_sq <= 1'b0;
            end
        end
    end

    // Phase comparator and lock detector
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pfd_up <= 1'b0;
            pfd_dn <= 1'b0;
            err_cnt <= 8'h00;
            lock_cnt <= 8'h00;
        end else begin
            pfd_up <= next_up;
            pfd_dn <= next_dn;
            if (comp_tick) begin
                err_cnt <= 8'h00;
                if (!in_window) begin
                    lock_cnt <= 8'h00;
                end else if (!locked) begin
                    lock_cnt <= lock_cnt + 8'h01;
                end
            end else if ((pfd_up | pfd_dn) && err_cnt != 8'hff) begin
                err_cnt <= err_cnt + 8'h01;
            end
        end
    end

    // Registered outputs
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            output_ports_oe_out <= 8'h00;
            pump_up_out <= 1'b0;
            pump_down_out <= 1'b0;
            pump_current_select_out <= 1'b0;
            drive_output_off_out <= 1'b0;
            lock_flag_out <= 1'b0;
        end else begin
            output_ports_oe_out <= next_port_oe;
            pump_up_out <= pfd_up & ~pump_disable;
            pump_down_out <= pfd_dn & ~pump_disable;
            pump_current_select_out <= pump_current_select;
            drive_output_off_out <= drive_output_off;
            lock_flag_out <= locked;
        end
    end
endmodule
`default_nettype wire
